// [src/odm_core.sv]
// Digital control logic of the optical drive motor and regulator block.
// Assumes configuration bits arrive as clk_sys-domain ports from the serial
// register file; pins and the serial clock are synchronised here.
`timescale 1ns/1ps
module odm_core #(
    parameter int SOFT_START_CYCLES = odm_pkg::SOFT_START_CYCLES,
    parameter logic [11:0] SLED_DEAD_BAND = 12'h020,
    parameter logic [7:0] BEMF_TH_3 = 8'h80
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Bring-up controls
    input wire logic sleep_release,
    input wire logic [4:0] channel_enable_bits,
    // Spindle
    input wire logic spindle_low_speed_select,
    input wire logic [1:0] spindle_sense_resistor_select,
    input wire logic [11:0] spindle_dac_code,
    input wire logic spindle_overcurrent_pin,
    input wire logic spindle_speed_high_pin,
    output logic spindle_pwm,
    output logic spindle_short_brake,
    output logic [8:0] spindle_sense_milliohm,
    // Sled
    input wire logic [11:0] sled_dac_code,
    input wire logic sled_end_detect_enable,
    input wire logic [1:0] sled_bemf_threshold_select,
    input wire logic [7:0] sled_bemf_level,
    output logic sled_out_p,
    output logic sled_out_n,
    output logic sled_stopped_flag,
    // Load, tracking, focus, tilt
    input wire logic load_request,
    output logic load_active,
    input wire logic differential_tilt_enable,
    input wire logic [11:0] focus_dac_code,
    input wire logic focus_write,
    input wire logic [11:0] tilt_dac_code,
    input wire logic tilt_write,
    output logic [11:0] focus_out,
    output logic [11:0] tilt_out,
    // Regulator
    input wire logic regulator_select_pin_low,
    input wire logic regulator_select_pin_high,
    input wire logic regulator_feedback_pin,
    input wire logic regulator_load_low_pin,
    input wire logic [1:0] regulator_output_raise,
    input wire logic discontinuous_mode_force,
    input wire logic discontinuous_mode_auto,
    input wire logic high_efficiency_select,
    output logic regulator_enable,
    output logic [1:0] regulator_voltage,
    output logic [5:0] regulator_raise_tenths,
    output logic [7:0] regulator_soft_start,
    output logic regulator_discontinuous,
    output logic regulator_high_efficiency,
    // Monitor
    input wire logic [7:0] monitor_select_register,
    input wire logic monitor_output_enable,
    output logic monitor_output_pin,
    // Serial status read
    input wire logic sclk_pin,
    input wire logic cs_b_pin,
    output logic sdo
);
    localparam int NPIN = 8;
    localparam int SS_DIV = SOFT_START_CYCLES / 256;
    localparam int ENA_SPM = 0;
    localparam int ENA_SLED = 1;
    localparam int ENA_TRACK = 2;
    localparam int ENA_FCS = 3;
    localparam int ENA_TLT = 4;

    // =========================================================
    // Reset release and pin synchronisers
    logic [1:0] rst_q;
    logic rst_n;
    logic [NPIN-1:0] pin_q1;
    logic [NPIN-1:0] pin_q2;
    logic oc_s, spd_s, vsl_s, vsh_s, fb_s, ldl_s, sclk_s, csb_s;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) rst_q <= 2'h0;
        else rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_q1 <= 8'h80;
            pin_q2 <= 8'h80;
        end else begin
            pin_q1 <= {cs_b_pin, sclk_pin, regulator_load_low_pin, regulator_feedback_pin,
                       regulator_select_pin_high, regulator_select_pin_low,
                       spindle_speed_high_pin, spindle_overcurrent_pin};
            pin_q2 <= pin_q1;
        end
    end
    assign {csb_s, sclk_s, ldl_s, fb_s, vsh_s, vsl_s, spd_s, oc_s} = pin_q2;

    function automatic logic [11:0] mag_of(input logic [11:0] code);
        mag_of = code[odm_pkg::SIGN_BIT] ? 12'(-code) : code;
    endfunction

    function automatic logic [7:0] duty_of(input logic [11:0] mag);
        duty_of = (mag >= odm_pkg::DAC_NEG_MAX) ? odm_pkg::PWM_FULL : 8'(mag >> odm_pkg::MAG_SHIFT);
    endfunction

    // =========================================================
    // PWM timebase
    logic [7:0] pwm_cnt;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) pwm_cnt <= 8'h00;
        else pwm_cnt <= pwm_cnt + 8'h01;
    end
    wire period_end = (pwm_cnt == odm_pkg::PWM_FULL);

    // =========================================================
    // Spindle
    logic [7:0] spm_limit;
    logic [7:0] spm_duty;
    wire spm_on = sleep_release && channel_enable_bits[ENA_SPM];
    wire spm_accel = !spindle_dac_code[odm_pkg::SIGN_BIT] && (spindle_dac_code > odm_pkg::SPM_DEAD_BAND);

    // Limit walks down while overcurrent persists so current hovers at the limit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) spm_limit <= odm_pkg::PWM_FULL;
        else if (period_end && oc_s && spm_limit != 8'h00) spm_limit <= spm_limit - 8'h01;
        else if (period_end && !oc_s && spm_limit != odm_pkg::PWM_FULL) spm_limit <= spm_limit + 8'h01;
    end

    always_comb begin
        spm_duty = spm_accel ? duty_of(spindle_dac_code) : 8'h00;
        if (spindle_low_speed_select && spm_duty > odm_pkg::LS_DUTY_MAX) spm_duty = odm_pkg::LS_DUTY_MAX;
        if (spm_duty > spm_limit) spm_duty = spm_limit;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            spindle_pwm <= 1'b0;
            spindle_short_brake <= 1'b0;
            spindle_sense_milliohm <= odm_pkg::RSENSE_00;
        end else begin
            spindle_pwm <= spm_on && (pwm_cnt < spm_duty);
            spindle_short_brake <= spm_on && spindle_dac_code[odm_pkg::SIGN_BIT] &&
                (spindle_low_speed_select || (spd_s && spindle_dac_code <= odm_pkg::SPM_SHORT_BRAKE_EDGE));
            case (spindle_sense_resistor_select)
                2'h0: spindle_sense_milliohm <= odm_pkg::RSENSE_00;
                2'h1: spindle_sense_milliohm <= odm_pkg::RSENSE_01;
                2'h2: spindle_sense_milliohm <= odm_pkg::RSENSE_10;
                default: spindle_sense_milliohm <= odm_pkg::RSENSE_11;
            endcase
        end
    end

    // =========================================================
    // Sled drive and end detection
    wire sled_on = sleep_release && channel_enable_bits[ENA_SLED];
    wire sled_dead = mag_of(sled_dac_code) <= SLED_DEAD_BAND;
    wire [7:0] sled_duty = duty_of(mag_of(sled_dac_code));
    logic [1:0] sled_dir_q;
    logic [7:0] bemf_th;
    wire [1:0] sled_dir = (sled_dead || !sled_on) ? 2'h0 : (sled_dac_code[odm_pkg::SIGN_BIT] ? 2'h2 : 2'h1);
    wire sled_zero_cross = (sled_dir != sled_dir_q) && (sled_dir_q != 2'h0);

    always_comb begin
        case (sled_bemf_threshold_select)
            2'h0: bemf_th = odm_pkg::BEMF_TH_0;
            2'h1: bemf_th = odm_pkg::BEMF_TH_1;
            2'h2: bemf_th = odm_pkg::BEMF_TH_2;
            default: bemf_th = BEMF_TH_3;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sled_out_p <= 1'b0;
            sled_out_n <= 1'b0;
            sled_dir_q <= 2'h0;
        end else begin
            sled_dir_q <= sled_dir;
            sled_out_p <= sled_dir[0] && (pwm_cnt < sled_duty || sled_duty == odm_pkg::PWM_FULL);
            sled_out_n <= sled_dir[1] && (pwm_cnt < sled_duty || sled_duty == odm_pkg::PWM_FULL);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) sled_stopped_flag <= 1'b0;
        else if (sled_end_detect_enable && sled_zero_cross) begin
            if (sled_bemf_level < bemf_th) sled_stopped_flag <= 1'b1;
            else sled_stopped_flag <= 1'b0;
        end
    end

    // =========================================================
    // Load sharing and focus/tilt update
    wire act_busy = |channel_enable_bits[ENA_TLT:ENA_TRACK];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) load_active <= 1'b0;
        else load_active <= sleep_release && load_request && !act_busy;
    end

    logic [11:0] tilt_held;
    wire [12:0] f_ext = {focus_dac_code[11], focus_dac_code};
    wire [12:0] t_ext = {tilt_held[11], tilt_held};
    wire [12:0] d_sum = f_ext + t_ext;
    wire [12:0] d_dif = f_ext - t_ext;

    function automatic logic [11:0] sat12(input logic [12:0] v);
        if (v[12] != v[11]) sat12 = v[12] ? odm_pkg::DAC_NEG_MAX : odm_pkg::DAC_POS_MAX;
        else sat12 = v[11:0];
    endfunction

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tilt_held <= 12'h000;
            focus_out <= 12'h000;
            tilt_out <= 12'h000;
        end else begin
            if (tilt_write) tilt_held <= tilt_dac_code;
            if (differential_tilt_enable) begin
                if (focus_write) begin
                    focus_out <= sat12(d_sum);
                    tilt_out <= sat12(d_dif);
                end
            end else begin
                if (focus_write) focus_out <= focus_dac_code;
                if (tilt_write) tilt_out <= tilt_dac_code;
            end
        end
    end

    // =========================================================
    // Regulator control
    logic [11:0] fb_cnt;
    logic reg_disabled;
    logic [15:0] ss_div;
    odm_pkg::odm_vsel_t vsel;
    assign vsel = odm_pkg::odm_vsel_t'({vsh_s, vsl_s});

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fb_cnt <= 12'h000;
            reg_disabled <= 1'b0;
        end else if (!fb_s) begin
            fb_cnt <= 12'h000;
            reg_disabled <= 1'b0;
        end else if (fb_cnt < 12'(odm_pkg::FB_QUAL_CYCLES)) begin
            fb_cnt <= fb_cnt + 12'h001;
        end else begin
            reg_disabled <= 1'b1;
        end
    end

    // Soft-start restarts from zero whenever the regulator is disabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ss_div <= 16'h0000;
            regulator_soft_start <= 8'h00;
        end else if (reg_disabled) begin
            ss_div <= 16'h0000;
            regulator_soft_start <= 8'h00;
        end else if (regulator_soft_start != odm_pkg::PWM_FULL) begin
            if (ss_div >= 16'(SS_DIV - 1)) begin
                ss_div <= 16'h0000;
                regulator_soft_start <= regulator_soft_start + 8'h01;
            end else ss_div <= ss_div + 16'h0001;
        end
    end

    logic [5:0] raise;
    always_comb begin
        raise = 6'h00;
        if (vsel == odm_pkg::ODM_V1P2 || vsel == odm_pkg::ODM_V1P5) begin
            case (regulator_output_raise)
                2'h1: raise = odm_pkg::RAISE_A1;
                2'h2: raise = odm_pkg::RAISE_A2;
                2'h3: raise = odm_pkg::RAISE_A3;
                default: raise = 6'h00;
            endcase
        end else if (vsel == odm_pkg::ODM_V1P0) begin
            case (regulator_output_raise)
                2'h1: raise = odm_pkg::RAISE_B1;
                2'h2: raise = odm_pkg::RAISE_B2;
                2'h3: raise = odm_pkg::RAISE_B3;
                default: raise = 6'h00;
            endcase
        end
    end

    wire disc = discontinuous_mode_force || (discontinuous_mode_auto && ldl_s);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regulator_enable <= 1'b0;
            regulator_voltage <= 2'h0;
            regulator_raise_tenths <= 6'h00;
            regulator_discontinuous <= 1'b0;
            regulator_high_efficiency <= 1'b0;
        end else begin
            regulator_enable <= !reg_disabled;
            regulator_voltage <= vsel;
            regulator_raise_tenths <= raise;
            regulator_discontinuous <= disc && !reg_disabled;
            regulator_high_efficiency <= high_efficiency_select && disc && !reg_disabled &&
                (vsel != odm_pkg::ODM_V3P3);
        end
    end

    // =========================================================
    // Monitor mux and serial status shift-out
    wire [7:0] mon_src = {reg_disabled, regulator_discontinuous, load_active, sled_stopped_flag,
                          spindle_short_brake, spindle_pwm, oc_s, fb_s};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) monitor_output_pin <= 1'b0;
        else monitor_output_pin <= monitor_output_enable && |(monitor_select_register & mon_src);
    end

    // Status leaves MSB first; the flag is the first bit seen after select
    logic sclk_d;
    logic [7:0] stat_sh;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            stat_sh <= 8'h00;
            sdo <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            if (csb_s) stat_sh <= {sled_stopped_flag, reg_disabled, load_active, 5'h00};
            else if (sclk_d && !sclk_s) stat_sh <= {stat_sh[6:0], 1'b0};
            sdo <= !csb_s && stat_sh[7];
        end
    end

    // =========================================================
    // Checks
    a_ls_duty_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(spindle_low_speed_select) && $past(pwm_cnt) >= odm_pkg::LS_DUTY_MAX) |-> !spindle_pwm)
        else $error("ls duty above cap");
    a_ls_short_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (spm_on && spindle_low_speed_select && spindle_dac_code[11]) ##1 $stable(spindle_dac_code)
        |-> spindle_short_brake) else $error("ls brake not short");
    a_sled_dead_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sled_dead ##1 sled_dead |-> !sled_out_p && !sled_out_n) else $error("sled driven in dead band");
    a_stop_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sled_end_detect_enable && sled_zero_cross && sled_bemf_level < bemf_th) |=> sled_stopped_flag)
        else $error("stop flag not set");
    a_stop_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sled_end_detect_enable && sled_zero_cross && sled_bemf_level >= bemf_th) |=> !sled_stopped_flag)
        else $error("stop flag not cleared");
    a_load_exclusive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        load_active |-> $past(!act_busy)) else $error("load active with actuators");
    a_diff_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ($past(differential_tilt_enable) && !$past(focus_write)) |-> $stable(tilt_out) && $stable(focus_out))
        else $error("diff outputs moved without focus write");
    a_fb_qual: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(reg_disabled) |-> $past(fb_s, 2) && fb_cnt == 12'(odm_pkg::FB_QUAL_CYCLES))
        else $error("regulator disabled early");
    a_heff_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regulator_high_efficiency |-> regulator_discontinuous && regulator_voltage != 2'h0)
        else $error("high efficiency out of mode");
    a_monitor_or: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !monitor_output_enable |=> !monitor_output_pin) else $error("monitor driven while off");
endmodule : odm_core

// [src/odm_pkg.sv]
// Constants shared by the optical drive motor control logic.
// Assumes a 20 MHz system clock; all times are turned into cycle counts here.
package odm_pkg;
    // =========================================================
    // Clock and times
    localparam int CLK_PERIOD_NS = 50;
    localparam int FB_QUAL_TIME_US = 100;
    localparam int FB_QUAL_CYCLES = (FB_QUAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_START_TIME_US = 800;
    localparam int SOFT_START_CYCLES = (SOFT_START_TIME_US * 1000) / CLK_PERIOD_NS;

    // =========================================================
    // Codes and fields
    localparam int DAC_W = 12;
    localparam int PWM_W = 8;
    localparam logic [PWM_W-1:0] PWM_FULL = 8'hff;
    localparam logic [PWM_W-1:0] LS_DUTY_MAX = 8'h40;
    localparam logic [DAC_W-1:0] DAC_POS_MAX = 12'h7ff;
    localparam logic [DAC_W-1:0] DAC_NEG_MAX = 12'h800;
    localparam logic [DAC_W-1:0] SPM_DEAD_BAND = 12'h052;
    localparam logic [DAC_W-1:0] SPM_SHORT_BRAKE_EDGE = 12'ha00;
    localparam int SIGN_BIT = 11;
    localparam int MAG_SHIFT = 3;

    // Sense resistance in milliohm, indexed by the select code
    localparam logic [8:0] RSENSE_00 = 9'h0dc;
    localparam logic [8:0] RSENSE_01 = 9'h0c8;
    localparam logic [8:0] RSENSE_10 = 9'h10e;
    localparam logic [8:0] RSENSE_11 = 9'h0fa;

    // Back-EMF thresholds in mV
    localparam logic [7:0] BEMF_TH_0 = 8'h16;
    localparam logic [7:0] BEMF_TH_1 = 8'h2e;
    localparam logic [7:0] BEMF_TH_2 = 8'h56;

    // Regulator output raise, in tenths of a percent
    localparam logic [5:0] RAISE_A1 = 6'h14;
    localparam logic [5:0] RAISE_A2 = 6'h26;
    localparam logic [5:0] RAISE_A3 = 6'h36;
    localparam logic [5:0] RAISE_B1 = 6'h0d;
    localparam logic [5:0] RAISE_B2 = 6'h18;
    localparam logic [5:0] RAISE_B3 = 6'h21;

    typedef enum logic [1:0] {
        ODM_V3P3,
        ODM_V1P2,
        ODM_V1P0,
        ODM_V1P5
    } odm_vsel_t;

    localparam int STATUS_W = 8;
endpackage : odm_pkg

// [bench/odm_dsp_model.sv]
// Model of the DSP side that reads the serial status word.
// Assumes sdo shows the first bit soon after select and moves on each falling sclk.
`timescale 1ns/1ps
module odm_dsp_model (
    // Serial pins
    output logic sclk_pin = 1'b0,
    output logic cs_b_pin = 1'b1,
    input wire logic sdo,
    // Control
    input wire logic start,
    output logic [7:0] word = 8'h00,
    output logic done = 1'b0
);
    // =====================================================
    // Frame: sclk stands still outside it, 400 ns period inside
    always @(posedge start) begin
        done = 1'b0;
        // Off the clock edge so the pin synchronisers never race the frame
        #10;
        cs_b_pin = 1'b0;
        #400;
        for (int i = 7; i >= 0; i--) begin
            sclk_pin = 1'b1;
            #200;
            // Sampled late in the high phase, well clear of the shift on the falling edge
            word[i] = sdo;
            sclk_pin = 1'b0;
            #200;
        end
        cs_b_pin = 1'b1;
        done = 1'b1;
    end
endmodule : odm_dsp_model

// [bench/tb_top.sv]
// Self-checking bench for the optical drive motor control logic.
// Assumes the DSP model reads status frames; every other input is driven here.
`timescale 1ns/1ps
module tb_top;
    // =====================================================
    // Signals
    logic clk_sys;
    logic rst_b = 1'b0;
    logic sleep_release = 1'b0, spindle_low_speed_select = 1'b0, spindle_overcurrent_pin = 1'b0;
    logic spindle_speed_high_pin = 1'b0, sled_end_detect_enable = 1'b0, load_request = 1'b0;
    logic differential_tilt_enable = 1'b0, focus_write = 1'b0, tilt_write = 1'b0, regulator_load_low_pin = 1'b0;
    logic regulator_select_pin_low = 1'b0, regulator_select_pin_high = 1'b0, regulator_feedback_pin = 1'b0;
    logic discontinuous_mode_force = 1'b0, discontinuous_mode_auto = 1'b0, high_efficiency_select = 1'b0;
    logic monitor_output_enable = 1'b0, rd_start = 1'b0;
    logic [4:0] channel_enable_bits = 5'h00;
    logic [1:0] spindle_sense_resistor_select = 2'h0, sled_bemf_threshold_select = 2'h0, regulator_output_raise = 2'h0;
    logic [11:0] spindle_dac_code = 12'h000, sled_dac_code = 12'h000, focus_dac_code = 12'h000, tilt_dac_code = 12'h000;
    logic [7:0] sled_bemf_level = 8'h00, monitor_select_register = 8'h00, rd_word, ss_level;
    logic spindle_pwm, spindle_short_brake, sled_out_p, sled_out_n, sled_stopped_flag, load_active, rd_done;
    logic regulator_enable, regulator_discontinuous, regulator_high_efficiency, monitor_output_pin, sclk_pin, cs_b_pin, sdo;
    logic [8:0] spindle_sense_milliohm;
    logic [11:0] focus_out, tilt_out;
    logic [1:0] regulator_voltage;
    logic [5:0] regulator_raise_tenths;
    int fail_count = 0;
    int checks_done = 0;

    odm_core #(.SOFT_START_CYCLES(512)) i_odm_core (
        .clk_sys, .rst_b, .sleep_release, .channel_enable_bits, .spindle_low_speed_select,
        .spindle_sense_resistor_select, .spindle_dac_code, .spindle_overcurrent_pin, .spindle_speed_high_pin,
        .spindle_pwm, .spindle_short_brake, .spindle_sense_milliohm, .sled_dac_code, .sled_end_detect_enable,
        .sled_bemf_threshold_select, .sled_bemf_level, .sled_out_p, .sled_out_n, .sled_stopped_flag,
        .load_request, .load_active, .differential_tilt_enable, .focus_dac_code, .focus_write, .tilt_dac_code,
        .tilt_write, .focus_out, .tilt_out, .regulator_select_pin_low, .regulator_select_pin_high,
        .regulator_feedback_pin, .regulator_load_low_pin, .regulator_output_raise, .discontinuous_mode_force,
        .discontinuous_mode_auto, .high_efficiency_select, .regulator_enable, .regulator_voltage,
        .regulator_raise_tenths, .regulator_soft_start(ss_level), .regulator_discontinuous, .regulator_high_efficiency,
        .monitor_select_register, .monitor_output_enable, .monitor_output_pin, .sclk_pin, .cs_b_pin, .sdo
    );
    odm_dsp_model i_odm_dsp_model (.sclk_pin, .cs_b_pin, .sdo, .start(rd_start), .word(rd_word), .done(rd_done));

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    // Waits 1 ns so the compare never races the edge's own updates
    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        #1;
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic t_sense;
        logic [8:0] ohm [4] = '{9'h0dc, 9'h0c8, 9'h10e, 9'h0fa};
        chk("sense_rst", 12'(spindle_sense_milliohm), 12'h0dc);
        for (int i = 0; i < 4; i++) begin
            wt(1);
            spindle_sense_resistor_select <= 2'(i);
            wt(2);
            chk("sense", 12'(spindle_sense_milliohm), 12'(ohm[i]));
        end
    endtask : t_sense
    task automatic t_reg;
        logic [5:0] a [4] = '{6'h00, 6'h14, 6'h26, 6'h36};
        logic [5:0] b [4] = '{6'h00, 6'h0d, 6'h18, 6'h21};
        for (int v = 0; v < 4; v++) begin
            for (int r = 1; r < 4; r++) begin
                wt(1);
                {regulator_select_pin_high, regulator_select_pin_low} <= 2'(v);
                regulator_output_raise <= 2'(r);
                wt(5);
                chk("vsel", 12'(regulator_voltage), 12'(v));
                if (v != 0) chk("raise", 12'(regulator_raise_tenths), 12'((v == 2) ? b[r] : a[r]));
            end
        end
        wt(1);
        discontinuous_mode_force <= 1'b1;
        high_efficiency_select <= 1'b1;
        wt(3);
        chk("disc_force", 12'(regulator_discontinuous), 12'h001);
        chk("heff_1v5", 12'(regulator_high_efficiency), 12'h001);
        wt(1);
        {regulator_select_pin_high, regulator_select_pin_low} <= 2'h0;
        discontinuous_mode_force <= 1'b0;
        discontinuous_mode_auto <= 1'b1;
        regulator_load_low_pin <= 1'b1;
        wt(5);
        chk("disc_auto", 12'(regulator_discontinuous), 12'h001);
        chk("heff_3v3", 12'(regulator_high_efficiency), 12'h000);
        wt(1);
        regulator_load_low_pin <= 1'b0;
        wt(5);
        chk("disc_heavy", 12'(regulator_discontinuous), 12'h000);
        wt(1);
        regulator_feedback_pin <= 1'b1;
        wt(1990);
        chk("reg_hold", 12'(regulator_enable), 12'h001);
        wt(20);
        chk("reg_off", 12'(regulator_enable), 12'h000);
        chk("ss_off", 12'(ss_level), 12'h000);
        wt(1);
        regulator_feedback_pin <= 1'b0;
        wt(400);
        chk("ss_ramp", 12'(ss_level != 8'h00 && ss_level != 8'hff), 12'h001);
        wt(200);
        chk("ss_done", 12'(ss_level), 12'h0ff);
    endtask : t_reg
    task automatic t_spin;
        int hi = 0;
        wt(1);
        channel_enable_bits <= 5'h01;
        spindle_low_speed_select <= 1'b1;
        spindle_dac_code <= 12'hf00;
        wt(4);
        chk("brake_ls", 12'(spindle_short_brake), 12'h001);
        wt(1);
        spindle_dac_code <= 12'h7ff;
        wt(600);
        repeat (256) @(negedge clk_sys) hi += int'(spindle_pwm === 1'b1);
        chk("ls_duty", 12'(hi >= 1 && hi <= 64), 12'h001);
        wt(1);
        hi = 0;
        spindle_low_speed_select <= 1'b0;
        spindle_overcurrent_pin <= 1'b1;
        wt(1024);
        repeat (256) @(negedge clk_sys) hi += int'(spindle_pwm === 1'b1);
        chk("oc_duty", 12'(hi >= 1 && hi < 255), 12'h001);
        wt(1);
        spindle_overcurrent_pin <= 1'b0;
        spindle_dac_code <= 12'hf00;
        wt(4);
        chk("brake_slow", 12'(spindle_short_brake), 12'h000);
        wt(1);
        spindle_speed_high_pin <= 1'b1;
        spindle_dac_code <= 12'h900;
        wt(5);
        chk("brake_fast", 12'(spindle_short_brake), 12'h001);
        wt(1);
        spindle_speed_high_pin <= 1'b0;
    endtask : t_spin
    task automatic t_sled;
        int hi = 0;
        wt(1);
        channel_enable_bits <= 5'h02;
        sled_end_detect_enable <= 1'b1;
        sled_bemf_threshold_select <= 2'h1;
        sled_bemf_level <= 8'h28;
        sled_dac_code <= 12'h200;
        wt(4);
        sled_dac_code <= 12'he00;
        wt(4);
        chk("stop_set", 12'(sled_stopped_flag), 12'h001);
        wt(1);
        rd_start <= 1'b1;
        for (int i = 0; i < 100 && rd_done !== 1'b1; i++) wt(1);
        chk("rd_done", 12'(rd_done), 12'h001);
        chk("status", 12'(rd_word), 12'h080);
        wt(1);
        rd_start <= 1'b0;
        sled_bemf_level <= 8'h32;
        sled_dac_code <= 12'h200;
        wt(4);
        chk("stop_clear", 12'(sled_stopped_flag), 12'h000);
        wt(1);
        sled_dac_code <= 12'h7ff;
        wt(3);
        chk("sled_pos_max", 12'({sled_out_p, sled_out_n}), 12'h002);
        wt(1);
        sled_dac_code <= 12'h800;
        wt(3);
        chk("sled_neg_max", 12'({sled_out_p, sled_out_n}), 12'h001);
        wt(1);
        sled_dac_code <= 12'h020;
        wt(3);
        repeat (256) @(negedge clk_sys) hi += int'(sled_out_p !== 1'b0 || sled_out_n !== 1'b0);
        chk("sled_dead", 12'(hi), 12'h000);
    endtask : t_sled
    task automatic t_load;
        wt(1);
        channel_enable_bits <= 5'h04;
        load_request <= 1'b1;
        monitor_select_register <= 8'h20;
        wt(3);
        chk("load_excl", 12'(load_active), 12'h000);
        wt(1);
        channel_enable_bits <= 5'h00;
        monitor_output_enable <= 1'b1;
        wt(4);
        chk("load_on", 12'(load_active), 12'h001);
        chk("monitor", 12'(monitor_output_pin), 12'h001);
    endtask : t_load
    task automatic t_tilt;
        wt(1);
        differential_tilt_enable <= 1'b1;
        tilt_dac_code <= 12'h200;
        focus_dac_code <= 12'h700;
        tilt_write <= 1'b1;
        wt(1);
        tilt_write <= 1'b0;
        wt(2);
        chk("tilt_held", 12'(tilt_out), 12'h000);
        wt(1);
        focus_write <= 1'b1;
        wt(1);
        focus_write <= 1'b0;
        wt(2);
        chk("focus_sum", focus_out, 12'h7ff);
        chk("tilt_diff", tilt_out, 12'h500);
    endtask : t_tilt

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        wt(10);
        rst_b <= 1'b1;
        wt(3);
        sleep_release <= 1'b1;
        t_sense;
        t_reg;
        t_spin;
        t_sled;
        t_load;
        t_tilt;
        report_and_stop;
    end
    // A run needs about 5300 cycles; this cuts a hang after 20000
    initial begin
        #1000000;
        fail_count++;
        report_and_stop;
    end
endmodule : tb_top
